// ==== gpp_board.sv ====
// Purpose: board-side model of the port pins
// Assumes: pad controls from gpp_port
// Notes: undriven pins without pull toggle every clock
`timescale 1ns/1ps
`default_nettype none
module gpp_board (
  // clock
  input wire logic clk_i,
  // pad controls and board drive
  input wire gpp_pkg::gpp_pad_s pad_i,
  input wire logic [15:0] ext_val_i,
  input wire logic [15:0] ext_en_i,
  // resolved levels
  output logic [15:0] pin_o
);
  // a floating pin must never settle to a level the design could pass off as real
  logic [15:0] float_r = 16'h5a5a;
  always @(posedge clk_i) float_r <= ~float_r;
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      if (pad_i.oe[i]) pin_o[i] = pad_i.dout[i];
      else if (ext_en_i[i]) pin_o[i] = ext_val_i[i];
      else if (pad_i.pull_en[i]) pin_o[i] = pad_i.pull_up[i];
      else pin_o[i] = float_r[i];
    end
  end
endmodule
`default_nettype wire

// ==== gpp_pkg.sv ====
// Purpose: shared constants and types for the gpio port block
// Assumes: axi4-lite slave, 32-bit data, 16 pins per port
// Notes: register offsets are byte addresses
package gpp_pkg;
  localparam int unsigned NPIN = 16;
  localparam int unsigned AW = 8;
  localparam logic [7:0] OFF_DATA = 8'h00;
  localparam logic [7:0] OFF_DIR = 8'h04;
  localparam logic [7:0] OFF_PER = 8'h08;
  localparam logic [7:0] OFF_ODE = 8'h0c;
  localparam logic [7:0] OFF_DRV = 8'h10;
  localparam logic [7:0] OFF_SLEW = 8'h14;
  localparam logic [7:0] OFF_PUEN = 8'h18;
  localparam logic [7:0] OFF_PUSEL = 8'h1c;
  localparam logic [7:0] OFF_SET = 8'h20;
  localparam logic [7:0] OFF_CLR = 8'h24;
  localparam logic [7:0] OFF_RAW = 8'h28;
  localparam logic [7:0] OFF_IEN = 8'h2c;
  localparam logic [7:0] OFF_IPOL = 8'h30;
  localparam logic [7:0] OFF_EDGE = 8'h34;
  localparam logic [7:0] OFF_IMASK = 8'h38;
  localparam logic [15:0] RST_ZERO = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic [15:0] oe;
    logic [15:0] dout;
    logic [15:0] od;
    logic [15:0] drv_hi;
    logic [15:0] slew_slow;
    logic [15:0] pull_en;
    logic [15:0] pull_up;
    logic [15:0] periph;
  } gpp_pad_s;
endpackage

// ==== gpp_port.sv ====
// Purpose: 16-pin general purpose port with per-pin pad control and edge flags
// Assumes: single clock clk_i, synchronous active-low reset, axi4-lite slave
// Notes: pad_o carries pad controls; the pad cell resolves the pin wire
// What this block does
// [R1] each pin selects push-pull or open-drain output drive
// [R2] each pin holds a high/low drive strength bit used as output
// [R3] each pin holds a fast/slow slew bit used as output
// [R4] each pin has pull choice: none, up or down, independent of direction
// [R5] software writes a per-pin output level that drives an output pin
// [R6] masked set drives selected pins high, others unchanged
// [R7] masked clear drives selected output pins low, others unchanged
// [R8] no toggle register; software reads back, inverts and writes
// [R9] data read returns synced pin level for inputs, data register otherwise
// [R10] after reset all pins are inputs with pull disabled
// [R11] raw read returns unclocked pin or peripheral levels; software rereads
// [R12] each pin has its own interrupt detection condition setting
// [R13] detection selects rising edge, falling edge or none
// [R14] edge flags set only while detection enabled; cleared by pin mask
// [R15] direction bit per pin; output settings only apply as output
// [R16] each pin is owned by gpio or by a peripheral function
// [R17] registers are 16 bits, bit n is pin n; absent pins read zero
// [R18] input levels pass two flops before read or edge detection
//
// Implementation choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module gpp_port #(
  parameter logic [15:0] PIN_MASK = 16'hffff
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // axi4-lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pins and peripheral side
  input wire logic [15:0] pin_i,
  input wire logic [15:0] periph_in_i,
  output gpp_pkg::gpp_pad_s pad_o,
  // interrupt
  output logic irq_o
);
  logic [15:0] data_r;
  logic [15:0] dir_r;
  logic [15:0] per_r;
  logic [15:0] ode_r;
  logic [15:0] drv_r;
  logic [15:0] slew_r;
  logic [15:0] puen_r;
  logic [15:0] pusel_r;
  logic [15:0] ien_r;
  logic [15:0] ipol_r;
  logic [15:0] edge_r;
  logic [15:0] imask_r;
  logic [15:0] sync1_r;
  logic [15:0] sync2_r;
  logic [15:0] prev_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [1:0] wstrb_r;
  logic aw_have_r;
  logic w_have_r;
  logic wr_go;
  logic [15:0] wval;
  logic [15:0] rise;
  logic [15:0] fall;
  logic [15:0] hit;
  logic [15:0] raw;
  logic wr_hit;
  logic [15:0] rd_val;
  logic rd_hit;

  // write channel: take address and data in either order, answer after both
  // both readies stay low while a response waits, so only one write is ever open
  assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
  assign s_axi_wready = !w_have_r && !s_axi_bvalid;
  assign wr_go = aw_have_r && w_have_r && !s_axi_bvalid;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 2'b00;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= gpp_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb[1:0];
      end
      if (wr_go) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? gpp_pkg::RESP_OKAY : gpp_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // byte lanes merge into the old value; absent pins never store
  function automatic logic [15:0] merge(input logic [15:0] old);
    logic [15:0] v;
    v = old;
    if (wstrb_r[0]) v[7:0] = wdata_r[7:0];
    if (wstrb_r[1]) v[15:8] = wdata_r[15:8];
    return v & PIN_MASK; // [R17]
  endfunction

  // masked set/clear use the mask as given, gated by present pins
  assign wval = merge(16'h0000);

  always_comb begin
    unique case (awaddr_r)
      gpp_pkg::OFF_DATA,
      gpp_pkg::OFF_DIR,
      gpp_pkg::OFF_PER,
      gpp_pkg::OFF_ODE,
      gpp_pkg::OFF_DRV,
      gpp_pkg::OFF_SLEW,
      gpp_pkg::OFF_PUEN,
      gpp_pkg::OFF_PUSEL,
      gpp_pkg::OFF_SET,
      gpp_pkg::OFF_CLR,
      gpp_pkg::OFF_RAW,
      gpp_pkg::OFF_IEN,
      gpp_pkg::OFF_IPOL,
      gpp_pkg::OFF_EDGE,
      gpp_pkg::OFF_IMASK: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // output level register: direct write, masked set, masked clear
  // clear skips input pins, so their stored level survives a later turn to output
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      data_r <= gpp_pkg::RST_ZERO;
    end else if (wr_go) begin
      if (awaddr_r == gpp_pkg::OFF_DATA) begin
        data_r <= merge(data_r); // [R5]
      end else if (awaddr_r == gpp_pkg::OFF_SET) begin
        data_r <= data_r | wval; // [R6]
      end else if (awaddr_r == gpp_pkg::OFF_CLR) begin
        data_r <= data_r & ~(wval & dir_r); // [R7]
      end
    end
  end

  // pad configuration registers, all inputs with no pull after reset
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      dir_r <= gpp_pkg::RST_ZERO; // [R10]
      per_r <= gpp_pkg::RST_ZERO;
      ode_r <= gpp_pkg::RST_ZERO;
      drv_r <= gpp_pkg::RST_ZERO;
      slew_r <= gpp_pkg::RST_ZERO;
      puen_r <= gpp_pkg::RST_ZERO; // [R10]
      pusel_r <= gpp_pkg::RST_ZERO;
    end else if (wr_go) begin
      if (awaddr_r == gpp_pkg::OFF_DIR) dir_r <= merge(dir_r); // [R15]
      if (awaddr_r == gpp_pkg::OFF_PER) per_r <= merge(per_r); // [R16]
      if (awaddr_r == gpp_pkg::OFF_ODE) ode_r <= merge(ode_r); // [R1]
      if (awaddr_r == gpp_pkg::OFF_DRV) drv_r <= merge(drv_r); // [R2]
      if (awaddr_r == gpp_pkg::OFF_SLEW) slew_r <= merge(slew_r); // [R3]
      if (awaddr_r == gpp_pkg::OFF_PUEN) puen_r <= merge(puen_r); // [R4]
      if (awaddr_r == gpp_pkg::OFF_PUSEL) pusel_r <= merge(pusel_r); // [R4]
    end
  end

  // interrupt configuration: enable plus polarity gives rise, fall or none
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ien_r <= gpp_pkg::RST_ZERO;
      ipol_r <= gpp_pkg::RST_ZERO;
      imask_r <= gpp_pkg::RST_ZERO;
    end else if (wr_go) begin
      if (awaddr_r == gpp_pkg::OFF_IEN) ien_r <= merge(ien_r); // [R12]
      if (awaddr_r == gpp_pkg::OFF_IPOL) ipol_r <= merge(ipol_r); // [R13]
      if (awaddr_r == gpp_pkg::OFF_IMASK) imask_r <= merge(imask_r);
    end
  end

  // pins cross into the clock domain before edge detection or the data read looks at them
  // prev_r clears while a pin may idle high, so the first compare can see a rise;
  // harmless, since ien_r is cleared by the same reset and no flag can set
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sync1_r <= gpp_pkg::RST_ZERO;
      sync2_r <= gpp_pkg::RST_ZERO;
      prev_r <= gpp_pkg::RST_ZERO;
    end else begin
      sync1_r <= pin_i; // [R18]
      sync2_r <= sync1_r; // [R18]
      prev_r <= sync2_r;
    end
  end

  // per-pin edge detect; ipol 0 is rising, 1 is falling
  genvar g;
  generate
    for (g = 0; g < gpp_pkg::NPIN; g++) begin : g_edge
      assign rise[g] = sync2_r[g] & ~prev_r[g];
      assign fall[g] = ~sync2_r[g] & prev_r[g];
      assign hit[g] = ien_r[g] & PIN_MASK[g] & (ipol_r[g] ? fall[g] : rise[g]); // [R13]
      // unclocked path: peripheral level when the peripheral owns the pin
      // no synchroniser here on purpose; software must reread for a stable value
      assign raw[g] = PIN_MASK[g] & (per_r[g] ? periph_in_i[g] : pin_i[g]); // [R11]
    end
  endgenerate

  // sticky flags, write one to clear; a new edge beats a same-cycle clear
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      edge_r <= gpp_pkg::RST_ZERO;
    end else if (wr_go && awaddr_r == gpp_pkg::OFF_EDGE) begin
      edge_r <= (edge_r & ~wval) | hit; // [R14]
    end else begin
      edge_r <= edge_r | hit; // [R14]
    end
  end

  assign irq_o = |(edge_r & imask_r);

  // pad drive: output settings only matter while the pin is an output
  // pull and ownership settings pass through whatever the direction
  always_comb begin
    pad_o.periph = per_r; // [R16]
    pad_o.pull_en = puen_r; // [R4]
    pad_o.pull_up = pusel_r;
    pad_o.drv_hi = drv_r & dir_r; // [R2]
    pad_o.slew_slow = slew_r & dir_r; // [R3]
    pad_o.od = ode_r & dir_r; // [R1]
    pad_o.dout = data_r & dir_r; // [R5]
    // open drain only drives while low
    pad_o.oe = dir_r & ~per_r & ~(ode_r & data_r); // [R1] [R15]
  end

  // read channel, one word answered the cycle after the address is taken
  // rd_val decodes the live address and is captured only on the accepting edge
  always_comb begin
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      gpp_pkg::OFF_DATA: rd_val = (sync2_r & ~dir_r) | (data_r & dir_r); // [R9]
      gpp_pkg::OFF_DIR: rd_val = dir_r;
      gpp_pkg::OFF_PER: rd_val = per_r;
      gpp_pkg::OFF_ODE: rd_val = ode_r;
      gpp_pkg::OFF_DRV: rd_val = drv_r;
      gpp_pkg::OFF_SLEW: rd_val = slew_r;
      gpp_pkg::OFF_PUEN: rd_val = puen_r;
      gpp_pkg::OFF_PUSEL: rd_val = pusel_r;
      gpp_pkg::OFF_SET, gpp_pkg::OFF_CLR: rd_val = 16'h0000;
      gpp_pkg::OFF_RAW: rd_val = raw; // [R11]
      gpp_pkg::OFF_IEN: rd_val = ien_r;
      gpp_pkg::OFF_IPOL: rd_val = ipol_r;
      gpp_pkg::OFF_EDGE: rd_val = edge_r;
      gpp_pkg::OFF_IMASK: rd_val = imask_r;
      default: begin
        rd_val = 16'h0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= gpp_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {16'h0000, rd_val & PIN_MASK}; // [R17]
      s_axi_rresp <= rd_hit ? gpp_pkg::RESP_OKAY : gpp_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== gpp_props.sv ====
// Purpose: port checks for gpp_port
// Assumes: one clock, sync active-low reset
// Notes: sees top ports only
`timescale 1ns/1ps
`default_nettype none
module gpp_props #(parameter logic [15:0] PIN_MASK = 16'hffff) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // bus
  input wire logic s_axi_arready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  // pins
  input wire gpp_pkg::gpp_pad_s pad_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  AST_RST_IDLE: assert property ($rose(rst_n_i) |-> pad_o == '0 && !irq_o)
    else $error("pads not idle");
  AST_RD_ANS: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read late");
  AST_RD_HOLD: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read dropped");
  AST_AR_REF: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read overlap");
  AST_WR_HOLD: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  AST_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper bits set");
  AST_ABSENT: assert property (
    ((pad_o.oe | pad_o.dout | pad_o.pull_en | pad_o.periph) & ~PIN_MASK) == 16'h0000)
    else $error("absent pin active");
  AST_OD: assert property ((pad_o.oe & pad_o.od & pad_o.dout) == 16'h0000)
    else $error("open drain drives high");
  AST_PER: assert property ((pad_o.oe & pad_o.periph) == 16'h0000)
    else $error("peripheral pin driven");
endmodule
bind gpp_port gpp_props #(.PIN_MASK(PIN_MASK)) u_props (.clk_i, .rst_n_i, .s_axi_arready,
  .s_axi_arvalid, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_bvalid, .s_axi_bready,
  .s_axi_bresp, .pad_o, .irq_o);
`default_nettype wire

// ==== tb_gpio_port_pin_control.sv ====
// Purpose: self-checking bench for gpp_port
// Assumes: axi4-lite master tasks, board model on the pins
// Notes: pin 15 absent to exercise the mask
`timescale 1ns/1ps
`default_nettype none
module tb_gpio_port_pin_control;
  localparam logic [15:0] PM = 16'h7fff;
  localparam logic [1:0] ERR = gpp_pkg::RESP_SLVERR;
  logic clk_i = 1'h0;
  logic rst_n_i = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'h0;
  logic s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0;
  logic s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_o;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [15:0] pin_i;
  logic [15:0] periph_in_i = 16'h0001;
  logic [15:0] ext_val = 16'ha500;
  gpp_pkg::gpp_pad_s pad_o;
  int fail_count = 0;
  int tests_run = 0;
  logic [7:0] ta [10] = '{gpp_pkg::OFF_DIR, gpp_pkg::OFF_PER, gpp_pkg::OFF_ODE, gpp_pkg::OFF_DRV,
    gpp_pkg::OFF_SLEW, gpp_pkg::OFF_PUEN, gpp_pkg::OFF_PUSEL, gpp_pkg::OFF_IEN,
    gpp_pkg::OFF_IPOL, gpp_pkg::OFF_IMASK};
  logic [15:0] tv [10] = '{16'hc3a5, 16'h0ff0, 16'h1234, 16'h8765, 16'h5aa5, 16'hf00f,
    16'h9999, 16'h0180, 16'h0100, 16'h8001};
  always #10 clk_i = ~clk_i;
  gpp_port #(.PIN_MASK(PM)) dut (.clk_i, .rst_n_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .pin_i, .periph_in_i, .pad_o, .irq_o);
  gpp_board board (.clk_i, .pad_i(pad_o), .ext_val_i(ext_val), .ext_en_i(16'hff00), .pin_o(pin_i));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (int n = 0; n < 40; n++) begin
      @(posedge clk_i);
      if (s_axi_bvalid) begin
        s_axi_bready <= 1'h0;
        chk(32'(s_axi_bresp), 32'(er));
        @(posedge clk_i);
        return;
      end
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end
    fail_count++;
    results();
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er = 2'h0);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (int n = 0; n < 40; n++) begin
      @(posedge clk_i);
      if (s_axi_rvalid) begin
        s_axi_rready <= 1'h0;
        chk(s_axi_rdata, ed);
        chk(32'(s_axi_rresp), 32'(er));
        @(posedge clk_i);
        return;
      end
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end
    fail_count++;
    results();
  endtask
  task automatic rst();
    rst_n_i <= 1'h0;
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'h1;
    @(posedge clk_i);
  endtask
  initial begin
    rst();
    for (int i = 0; i < 10; i++) rd(ta[i], 32'h0);
    chk(32'(|{pad_o, irq_o}), 32'h0);
    for (int i = 0; i < 10; i++) begin
      wr(ta[i], {16'hffff, tv[i]});
      rd(ta[i], {16'h0000, tv[i] & PM});
    end
    // output-only settings reach the pad only on pins whose direction is output
    chk(32'(pad_o.od), 32'(tv[2] & tv[0] & PM));
    chk(32'(pad_o.drv_hi), 32'(tv[3] & tv[0] & PM));
    chk(32'(pad_o.slew_slow), 32'(tv[4] & tv[0] & PM));
    chk(32'(pad_o.pull_en), 32'(tv[5] & PM));
    chk(32'(pad_o.pull_up), 32'(tv[6] & PM));
    chk(32'(pad_o.periph), 32'(tv[1] & PM));
    rst();
    chk(32'(|{pad_o, irq_o}), 32'h0);
    wr(gpp_pkg::OFF_DIR, 32'h00ff);
    wr(gpp_pkg::OFF_SET, 32'h0f0f);
    wr(gpp_pkg::OFF_CLR, 32'h0303);
    chk(32'(pad_o.dout), 32'h000c);
    rd(gpp_pkg::OFF_DATA, 32'h250c);
    // no toggle register: invert the read-back output byte and write it back
    wr(gpp_pkg::OFF_DATA, 32'h00f3);
    chk(32'(pad_o.dout), 32'h00f3);
    wr(gpp_pkg::OFF_PER, 32'h0001);
    rd(gpp_pkg::OFF_RAW, 32'h25f3);
    periph_in_i <= 16'h0000;
    rd(gpp_pkg::OFF_RAW, 32'h25f2);
    wr(gpp_pkg::OFF_ODE, 32'h0003);
    chk(32'(pad_o.oe), 32'h00fc);
    wr(gpp_pkg::OFF_IEN, 32'h0300);
    wr(gpp_pkg::OFF_IPOL, 32'h0200);
    wr(gpp_pkg::OFF_IMASK, 32'h0100);
    ext_val <= 16'ha600;
    repeat (6) @(posedge clk_i);
    rd(gpp_pkg::OFF_EDGE, 32'h0);
    ext_val <= 16'hb500;
    repeat (6) @(posedge clk_i);
    rd(gpp_pkg::OFF_EDGE, 32'h0300);
    chk(32'(irq_o), 32'h1);
    wr(gpp_pkg::OFF_IMASK, 32'h0);
    chk(32'(irq_o), 32'h0);
    wr(gpp_pkg::OFF_EDGE, 32'h0100);
    rd(gpp_pkg::OFF_EDGE, 32'h0200);
    wr(gpp_pkg::OFF_IMASK, 32'h0200);
    chk(32'(irq_o), 32'h1);
    wr(gpp_pkg::OFF_EDGE, 32'h0200);
    chk(32'(irq_o), 32'h0);
    wr(8'h3c, 32'hffff, ERR);
    rd(8'h3c, 32'h0, ERR);
    results();
  end
endmodule
`default_nettype wire
